//--- osf_defines.svh
// Constants for the oversampling averaging filter.
`ifndef OSF_DEFINES_SVH
`define OSF_DEFINES_SVH
`define OSF_SEL_NONE 3'h0
`define OSF_SEL_MAX 3'h6
`define OSF_SEL_BAD 3'h7
`define OSF_CHANNELS 6
`define OSF_SAMPLE_BITS 16
`define OSF_MAX_LOG2 6
`define OSF_STROBE_NS 4000
`define OSF_CLOCK_MHZ 250
`define OSF_STROBE_CYCLES ((`OSF_STROBE_NS * `OSF_CLOCK_MHZ) / 1000)
`endif

//--- osf_pkg.sv
// Types for the oversampling averaging filter.
package osf_pkg;
   typedef enum logic [1:0] {
      OSF_IDLE,
      OSF_REQ,
      OSF_WAIT,
      OSF_DONE
   } osf_state_t;
endpackage

//--- osf_accum_mem.sv
// Per-channel accumulator store with registered read data.
`timescale 1ns/1ns
`default_nettype none
module osf_accum_mem #(
   parameter int DEPTH = 6,
   parameter int WIDTH = 22
) (
   // Clock.
   input wire logic i_clock,
   // Write port.
   input wire logic i_we,
   input wire logic [$clog2(DEPTH)-1:0] i_waddr,
   input wire logic [WIDTH-1:0] i_wdata,
   // Read port.
   input wire logic [$clog2(DEPTH)-1:0] i_raddr,
   output logic [WIDTH-1:0] o_rdata
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [WIDTH-1:0] rdata_nxt;

   if (DEPTH < 2 || WIDTH < 1) begin : g_bad_params
      $error("osf_accum_mem: unsupported parameter values.");
   end

   always_comb begin
      rdata_nxt = mem[i_raddr];
   end

   always_ff @(posedge i_clock) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
      o_rdata <= rdata_nxt;
   end
endmodule
`default_nettype wire

//--- osf_filter.sv
// Oversampling averaging and decimation filter for a six-channel converter.
//
// Behaviour
// - Three-bit select: 000 no averaging, 001-110 ratio 2 to 64, 111 invalid.
// - First sample of each set is taken on the conversion-start rising edge.
// - Later samples of the set are taken on an internal sampling strobe.
// - All samples of a channel within one conversion are averaged together.
// - Exactly one 16-bit word per channel comes out per conversion.
`timescale 1ns/1ns
`default_nettype none
`include "osf_defines.svh"
module osf_filter #(
   parameter int CHANNELS = `OSF_CHANNELS,
   parameter int SAMPLE_BITS = `OSF_SAMPLE_BITS,
   parameter int STROBE_CYCLES = `OSF_STROBE_CYCLES
) (
   // Clock and reset.
   input wire logic i_clock,
   input wire logic i_rst_b,
   // Strap and conversion-start pins.
   input wire logic [2:0] i_oversample_ratio_select,
   input wire logic i_conversion_start_group_a,
   input wire logic i_conversion_start_group_b,
   // Converter core.
   input wire logic i_sample_valid,
   input wire logic [$clog2(CHANNELS)-1:0] i_sample_channel,
   input wire logic [SAMPLE_BITS-1:0] i_sample_data,
   output logic o_sample_request,
   // Decimated output.
   output logic o_result_valid,
   output logic [$clog2(CHANNELS)-1:0] o_result_channel,
   output logic [SAMPLE_BITS-1:0] o_result_data,
   output logic o_busy,
   output logic o_select_invalid
);
   localparam int CW = $clog2(CHANNELS);
   localparam int AW = SAMPLE_BITS + `OSF_MAX_LOG2;
   localparam int TW = $clog2(STROBE_CYCLES + 1);

   // A single channel would leave the channel fields with no bits.
   if (CHANNELS < 2 || SAMPLE_BITS < 2 || STROBE_CYCLES < 1) begin : g_bad_params
      $error("osf_filter: unsupported parameter values.");
   end

   // ----------------------------------------------------------------
   // Pin synchronisers and start edge detect.
   // ----------------------------------------------------------------
   logic [1:0] sa_r, sa_nxt, sb_r, sb_nxt;
   logic [2:0] sel_m_r, sel_m_nxt, sel_r, sel_nxt;
   logic start_prev_r, start_prev_nxt;
   logic start_level, start_rise;

   always_comb begin
      sa_nxt = {sa_r[0], i_conversion_start_group_a};
      sb_nxt = {sb_r[0], i_conversion_start_group_b};
      sel_m_nxt = i_oversample_ratio_select;
      sel_nxt = sel_m_r;
      start_level = sa_r[1] & sb_r[1];
      start_prev_nxt = start_level;
      start_rise = start_level & ~start_prev_r;
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         sa_r <= 2'h0;
         sb_r <= 2'h0;
         sel_m_r <= 3'h0;
         sel_r <= 3'h0;
         start_prev_r <= 1'b0;
      end else begin
         sa_r <= sa_nxt;
         sb_r <= sb_nxt;
         sel_m_r <= sel_m_nxt;
         sel_r <= sel_nxt;
         start_prev_r <= start_prev_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Ratio decode.
   // ----------------------------------------------------------------
   // An invalid select is treated as no averaging so the block never hangs.
   function automatic logic [2:0] ratio_log2(input logic [2:0] sel);
      if (sel > `OSF_SEL_MAX) begin
         ratio_log2 = 3'h0;
      end else begin
         ratio_log2 = sel;
      end
   endfunction

   function automatic logic [AW-1:0] extend(input logic [SAMPLE_BITS-1:0] d);
      extend = {{`OSF_MAX_LOG2{d[SAMPLE_BITS-1]}}, d};
   endfunction

   // ----------------------------------------------------------------
   // Sequencer.
   // ----------------------------------------------------------------
   osf_pkg::osf_state_t state_r, state_nxt;
   logic [2:0] shift_r, shift_nxt;
   logic [6:0] left_r, left_nxt;
   logic [TW-1:0] timer_r, timer_nxt;
   logic [CW-1:0] seen_r, seen_nxt;
   logic req_r, req_nxt;
   logic first_r, first_nxt;
   logic last_set;
   logic set_done;

   assign set_done = i_sample_valid && (i_sample_channel == CW'(CHANNELS - 1));
   assign last_set = (left_r == 7'h01);

   always_comb begin
      state_nxt = state_r;
      shift_nxt = shift_r;
      left_nxt = left_r;
      timer_nxt = timer_r;
      seen_nxt = seen_r;
      req_nxt = 1'b0;
      first_nxt = first_r;
      unique case (state_r)
         osf_pkg::OSF_IDLE: begin
            if (start_rise) begin
               shift_nxt = ratio_log2(sel_r);
               left_nxt = 7'h01 << ratio_log2(sel_r);
               first_nxt = 1'b1;
               req_nxt = 1'b1;
               state_nxt = osf_pkg::OSF_REQ;
            end
         end
         osf_pkg::OSF_REQ: begin
            if (set_done) begin
               first_nxt = 1'b0;
               left_nxt = left_r - 7'h01;
               timer_nxt = TW'(STROBE_CYCLES - 1);
               state_nxt = last_set ? osf_pkg::OSF_DONE : osf_pkg::OSF_WAIT;
            end
         end
         osf_pkg::OSF_WAIT: begin
            if (timer_r == '0) begin
               req_nxt = 1'b1;
               state_nxt = osf_pkg::OSF_REQ;
            end else begin
               timer_nxt = timer_r - TW'(1);
            end
         end
         osf_pkg::OSF_DONE: begin
            // Let the last result word drain before accepting a new start.
            if (seen_r == CW'(CHANNELS - 1)) begin
               seen_nxt = '0;
               state_nxt = osf_pkg::OSF_IDLE;
            end else begin
               seen_nxt = seen_r + CW'(1);
            end
         end
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         state_r <= osf_pkg::OSF_IDLE;
         shift_r <= 3'h0;
         left_r <= 7'h00;
         timer_r <= '0;
         seen_r <= '0;
         req_r <= 1'b0;
         first_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         shift_r <= shift_nxt;
         left_r <= left_nxt;
         timer_r <= timer_nxt;
         seen_r <= seen_nxt;
         req_r <= req_nxt;
         first_r <= first_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Accumulation and decimation.
   // ----------------------------------------------------------------
   // The accumulator read is one cycle late, so the incoming sample is
   // delayed a cycle to meet its running sum.
   logic acc_we_r, acc_we_nxt, first_d_r, first_d_nxt, last_d_r, last_d_nxt;
   logic [CW-1:0] ch_d_r, ch_d_nxt;
   logic [AW-1:0] smp_d_r, smp_d_nxt, acc_rd, sum;
   logic res_v_r, res_v_nxt;
   logic [CW-1:0] res_ch_r, res_ch_nxt;
   logic [SAMPLE_BITS-1:0] res_d_r, res_d_nxt;

   osf_accum_mem #(
      .DEPTH(CHANNELS),
      .WIDTH(AW)
   ) u_mem (
      .i_clock(i_clock),
      .i_we(acc_we_r),
      .i_waddr(ch_d_r),
      .i_wdata(sum),
      .i_raddr(i_sample_channel),
      .o_rdata(acc_rd)
   );

   always_comb begin
      acc_we_nxt = i_sample_valid && (state_r == osf_pkg::OSF_REQ);
      first_d_nxt = first_r;
      last_d_nxt = last_set;
      ch_d_nxt = i_sample_channel;
      smp_d_nxt = extend(i_sample_data);
      sum = first_d_r ? smp_d_r : acc_rd + smp_d_r;
      res_v_nxt = acc_we_r && last_d_r;
      res_ch_nxt = ch_d_r;
      res_d_nxt = res_d_r;
      if (acc_we_r && last_d_r) begin
         res_d_nxt = SAMPLE_BITS'($signed(sum) >>> shift_r);
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         acc_we_r <= 1'b0;
         first_d_r <= 1'b0;
         last_d_r <= 1'b0;
         ch_d_r <= '0;
         smp_d_r <= '0;
         res_v_r <= 1'b0;
         res_ch_r <= '0;
         res_d_r <= '0;
      end else begin
         acc_we_r <= acc_we_nxt;
         first_d_r <= first_d_nxt;
         last_d_r <= last_d_nxt;
         ch_d_r <= ch_d_nxt;
         smp_d_r <= smp_d_nxt;
         res_v_r <= res_v_nxt;
         res_ch_r <= res_ch_nxt;
         res_d_r <= res_d_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs.
   // ----------------------------------------------------------------
   logic busy_r, busy_nxt, bad_r, bad_nxt;

   always_comb begin
      busy_nxt = (state_nxt != osf_pkg::OSF_IDLE);
      bad_nxt = (sel_r == `OSF_SEL_BAD);
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         busy_r <= 1'b0;
         bad_r <= 1'b0;
      end else begin
         busy_r <= busy_nxt;
         bad_r <= bad_nxt;
      end
   end

   assign o_sample_request = req_r;
   assign o_result_valid = res_v_r;
   assign o_result_channel = res_ch_r;
   assign o_result_data = res_d_r;
   assign o_busy = busy_r;
   assign o_select_invalid = bad_r;
endmodule
`default_nettype wire

//--- osf_filter_props.sv
// Concurrent checks on the ports of the oversampling averaging filter.
`timescale 1ns/1ns
`default_nettype none
module osf_filter_props #(
   parameter int CHANNELS = 6,
   parameter int SAMPLE_BITS = 16,
   parameter int STROBE_CYCLES = 4
) (
   // Clock and reset.
   input wire logic i_clock,
   input wire logic i_rst_b,
   // Pins and core side.
   input wire logic [2:0] i_oversample_ratio_select,
   input wire logic i_conversion_start_group_a,
   input wire logic i_conversion_start_group_b,
   input wire logic i_sample_valid,
   input wire logic [$clog2(CHANNELS)-1:0] i_sample_channel,
   // Outputs.
   input wire logic o_sample_request,
   input wire logic o_result_valid,
   input wire logic [$clog2(CHANNELS)-1:0] o_result_channel,
   input wire logic o_busy,
   input wire logic o_select_invalid
);
   // The tail of a set covers the strobe wait plus the last result burst.
   localparam int LIM = STROBE_CYCLES + 12;
   localparam int CW = $clog2(CHANNELS);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);
   a_invalid_flag: assert property ((i_oversample_ratio_select == 3'h7) [*5] |-> o_select_invalid)
      else $error("invalid select not flagged");
   a_first_request: assert property (!o_busy && $rose(i_conversion_start_group_a && i_conversion_start_group_b)
      |-> ##[2:6] o_sample_request)
      else $error("no request after start edge");
   a_request_pulse: assert property (o_sample_request |=> !o_sample_request)
      else $error("request longer than one cycle");
   a_strobe_next_set: assert property (o_busy && i_sample_valid && i_sample_channel == CW'(CHANNELS - 1)
      |-> ##[1:LIM] (o_sample_request || !o_busy))
      else $error("no internal strobe after set");
   a_result_lag: assert property (o_result_valid |-> $past(i_sample_valid, 2)
      && o_result_channel == $past(i_sample_channel, 2))
      else $error("result not two cycles after sample");
   a_result_busy: assert property (o_result_valid |-> o_busy)
      else $error("result outside conversion");
   cover property (o_result_valid && o_result_channel == CW'(CHANNELS - 1));
   cover property (o_select_invalid && o_busy);
   cover property ($rose(i_conversion_start_group_a && i_conversion_start_group_b) && o_busy);
endmodule
bind osf_filter osf_filter_props #(.CHANNELS(CHANNELS), .SAMPLE_BITS(SAMPLE_BITS), .STROBE_CYCLES(STROBE_CYCLES))
   i_props (.i_clock, .i_rst_b, .i_oversample_ratio_select, .i_conversion_start_group_a,
   .i_conversion_start_group_b, .i_sample_valid, .i_sample_channel, .o_sample_request,
   .o_result_valid, .o_result_channel, .o_busy, .o_select_invalid);
`default_nettype wire

//--- osf_core_model.sv
// Converter core model: answers each request with one sample per channel.
`timescale 1ns/1ns
`default_nettype none
module osf_core_model (
   // Clock and filter side.
   input wire logic i_clock,
   input wire logic i_busy,
   input wire logic i_req,
   // Sample stream.
   output logic o_valid,
   output logic [2:0] o_ch,
   output logic [15:0] o_data
);
   int k = 0;
   int n = 0;
   initial begin
      o_valid = 1'b0;
      o_ch = 3'h0;
      o_data = 16'h0000;
   end
   // Idle data toggles so a stale word is never mistaken for a sample.
   always @(posedge i_clock) begin
      if (n > 0) begin
         o_valid <= 1'b1;
         o_ch <= 3'(6 - n);
         o_data <= 16'(16'hC000 + (6 - n) * 16'h1357 + k * 3);
         n <= n - 1;
         if (n == 1) k <= k + 1;
      end else begin
         o_valid <= 1'b0;
         o_data <= ~o_data;
      end
      if (i_req) n <= 6;
      if (!i_busy && !i_req) k <= 0;
   end
endmodule
`default_nettype wire

//--- oversampling_averaging_filter_tb.sv
// Self-checking bench for the oversampling averaging filter.
`timescale 1ns/1ns
`default_nettype none
module oversampling_averaging_filter_tb;
   logic i_clock = 1'b0;
   logic i_rst_b = 1'b0;
   logic cs_a = 1'b0;
   logic cs_b = 1'b0;
   logic [2:0] sel = 3'h0;
   logic req, sv, rv, busy, bad;
   logic [2:0] sch, rch;
   logic [15:0] sd, rd;
   int failures = 0;
   int n_compared = 0;
   int cyc = 0;
   always #2 i_clock = ~i_clock;
   osf_filter #(.STROBE_CYCLES(4)) i_dut (.i_clock(i_clock), .i_rst_b(i_rst_b),
      .i_oversample_ratio_select(sel), .i_conversion_start_group_a(cs_a), .i_conversion_start_group_b(cs_b),
      .i_sample_valid(sv), .i_sample_channel(sch), .i_sample_data(sd), .o_sample_request(req),
      .o_result_valid(rv), .o_result_channel(rch), .o_result_data(rd), .o_busy(busy), .o_select_invalid(bad));
   osf_core_model i_core (.i_clock(i_clock), .i_busy(busy), .i_req(req), .o_valid(sv), .o_ch(sch), .o_data(sd));
   task automatic print_verdict();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic check_count(input int got, input int exp);
      n_compared++;
      if (got != exp) begin
         failures++;
         $display("CHECK FAILED t=%0t count %0d exp %0d", $time, got, exp);
      end
   endtask
   function automatic logic [15:0] avg(input int ch, input int l);
      logic signed [21:0] s = 22'h000000;
      for (int k = 0; k < (1 << l); k++) s += 22'(signed'(16'(16'hC000 + ch * 16'h1357 + k * 3)));
      return 16'(s >>> l);
   endfunction
   // A second start while busy must be ignored, so it is raised mid-run.
   task automatic run_conv(input logic [2:0] s, input int l, input bit twice);
      int nreq = 0;
      int nres = 0;
      bit seen = 1'b0;
      @(negedge i_clock) sel = s;
      repeat (6) @(negedge i_clock);
      cs_a = 1'b1;
      cs_b = 1'b1;
      for (int i = 0; i < 8000 && !(seen && busy === 1'b0); i++) begin
         @(negedge i_clock);
         seen |= (busy === 1'b1);
         if (i == 3) {cs_a, cs_b} = 2'b00;
         if (twice && i == 10) {cs_a, cs_b} = 2'b11;
         if (req === 1'b1) nreq++;
         if (rv === 1'b1) begin
            check_word(16'(rch), 16'(nres));
            check_word(rd, avg(nres, l));
            nres++;
         end
      end
      check_count(nreq, 1 << l);
      check_count(nres, 6);
      check_word(16'(busy), 16'h0000);
      check_word(16'(bad), 16'(s == 3'h7));
      {cs_a, cs_b} = 2'b00;
      repeat (4 << l) @(negedge i_clock);
   endtask
   task automatic scen_each_ratio();
      for (int l = 0; l < 7; l++) run_conv(3'(l), l, 1'b0);
   endtask
   task automatic scen_start_while_busy();
      run_conv(3'h2, 2, 1'b1);
   endtask
   task automatic scen_invalid_select();
      run_conv(3'h7, 0, 1'b0);
   endtask
   always @(posedge i_clock) begin
      cyc++;
      if (cyc == 30000) begin
         failures++;
         print_verdict();
      end
   end
   initial begin
      repeat (20) @(negedge i_clock);
      i_rst_b = 1'b1;
      @(negedge i_clock);
      scen_each_ratio();
      scen_start_while_busy();
      scen_invalid_select();
      print_verdict();
   end
endmodule
`default_nettype wire
